// ---- src/adc_ctrl.sv ----
// Overview of operation
// - Align bit set: result right-justified, upper six high-result bits read zero.
// - Align bit clear: result left-justified, lower six low-result bits read zero.
// - High clock bit with two low bits picks Fosc divide or RC clock.
// - Control register 1 bits 5 and 4 always read zero.
// - Port config code decides which of eight pins are analog inputs.
// - Port config code selects supply or external pins as references.
// - Any reset forces all shared pins to analog input.
// - Reset clears control and flag registers, powers off, aborts running conversion.
// - Conversion continues during sleep only with the RC conversion clock.
// - Completion loads result, clears go flag, sets done flag together.
// - Result registers are not initialised by reset.
// - Conversion start disconnects hold capacitor, then successive approximation runs.
// - Writing go while powered and idle starts conversion; go reads one until done.
// - Clearing go mid-conversion aborts; result registers keep old value.
// - One conversion takes twelve conversion clock periods.
`timescale 1ns/100ps
module adc_ctrl #(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Wishbone slave
   input  wire logic          cyc_i,
   input  wire logic          stb_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] adr_i,
   input  wire logic [3:0]    sel_i,
   input  wire logic [31:0]   dat_i,
   output logic [31:0]        dat_o,
   output logic               ack_o,
   // Analog side
   input  wire logic          comp_i,
   input  wire logic          rc_clk_i,
   input  wire logic          sleep_i,
   output logic [9:0]         dac_o,
   output logic               hold_connect_o,
   output logic [2:0]         chan_o,
   output logic               power_on_o,
   output logic [7:0]         pin_analog_o,
   output logic               vref_pos_ext_o,
   output logic               vref_neg_ext_o,
   // Interrupt request
   output logic               irq_o
);
   import adc_pkg::*;
   default clocking cb_main @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Returns {vref_pos_ext, vref_neg_ext, analog pin mask}
   function automatic logic [9:0] port_decode(input logic [3:0] code);
      logic [9:0] r;
      r = 10'h000;
      unique case (code)
         4'h0:    r = {2'b00, 8'hFF};
         4'h1:    r = {2'b10, 8'hF7};
         4'h2:    r = {2'b00, 8'h1F};
         4'h3:    r = {2'b10, 8'h17};
         4'h4:    r = {2'b00, 8'h0B};
         4'h5:    r = {2'b10, 8'h03};
         4'h6:    r = {2'b00, 8'h00};
         4'h7:    r = {2'b00, 8'h00};
         4'h8:    r = {2'b11, 8'hF3};
         4'h9:    r = {2'b00, 8'h3F};
         4'hA:    r = {2'b10, 8'h37};
         4'hB:    r = {2'b11, 8'h33};
         4'hC:    r = {2'b11, 8'h13};
         4'hD:    r = {2'b11, 8'h03};
         4'hE:    r = {2'b00, 8'h01};
         default: r = {2'b11, 8'h01};
      endcase
      return r;
   endfunction

   conv_clk_if cc ();

   conv_state_t state_r;
   logic [1:0]  clk_lo_r;
   logic [2:0]  chan_r;
   logic        on_r;
   logic        align_r;
   logic        clk_hi_r;
   logic [3:0]  pcfg_r;
   logic [7:0]  res_hi_r;
   logic [7:0]  res_lo_r;
   logic        flag_r;
   logic        en_r;
   logic [3:0]  tad_cnt_r;
   logic [1:0]  rec_cnt_r;
   logic [9:0]  sar_r;
   logic [9:0]  mask_r;
   logic        ack_r;
   logic [31:0] dat_r;
   logic        hold_r;
   logic [7:0]  pin_r;
   logic        vpos_r;
   logic        vneg_r;
   logic        irq_r;

   logic        req;
   logic        wr;
   logic        wr_ctrl0;
   logic        wr_ctrl1;
   logic        wr_irq;
   logic        start;
   logic        abort;
   logic        complete;
   logic [7:0]  ctrl0_rd;
   logic [7:0]  ctrl1_rd;

   // Single wait state: ack rises one edge after the request is seen
   assign req      = cyc_i && stb_i && !ack_r;
   assign wr       = req && we_i && sel_i[0];
   assign wr_ctrl0 = wr && adr_i == OFS_CTRL0[AW-1:0];
   assign wr_ctrl1 = wr && adr_i == OFS_CTRL1[AW-1:0];
   assign wr_irq   = wr && adr_i == OFS_IRQ[AW-1:0];

   // Go ignored if power comes on in the same write
   assign start    = wr_ctrl0 && dat_i[CTRL0_GO_POS] && on_r && state_r == ST_IDLE;
   // Power-off also aborts, since the converter stops drawing current
   assign abort    = state_r == ST_CONV && !complete &&
                     ((wr_ctrl0 && (!dat_i[CTRL0_GO_POS] || !dat_i[CTRL0_ON_POS])));
   assign complete = state_r == ST_CONV && cc.tick && tad_cnt_r == TAD_PER_CONV - 4'h1;

   assign ctrl0_rd = {clk_lo_r, chan_r, state_r == ST_CONV, 1'b0, on_r};
   assign ctrl1_rd = {align_r, clk_hi_r, 2'b00, pcfg_r};

   assign cc.sel   = {clk_hi_r, clk_lo_r};
   assign cc.run   = state_r != ST_IDLE;
   assign cc.sleep = sleep_i;

   conv_tick_gen u_tick (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .rc_clk_i (rc_clk_i),
      .cc       (cc.gen)
   );

   // Bus answer and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req;
         if (req) begin
            unique case (adr_i)
               OFS_CTRL0[AW-1:0]:  dat_r <= {24'h00_0000, ctrl0_rd};
               OFS_CTRL1[AW-1:0]:  dat_r <= {24'h00_0000, ctrl1_rd};
               OFS_RES_HI[AW-1:0]: dat_r <= {24'h00_0000, res_hi_r};
               OFS_RES_LO[AW-1:0]: dat_r <= {24'h00_0000, res_lo_r};
               OFS_IRQ[AW-1:0]:    dat_r <= {30'h0000_0000, en_r, flag_r};
               default:            dat_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {clk_lo_r, chan_r, on_r} <= {CTRL0_RST[7:3], CTRL0_RST[0]};
         {align_r, clk_hi_r}      <= CTRL1_RST[7:6];
         pcfg_r                   <= CTRL1_RST[3:0];
      end else begin
         if (wr_ctrl0) begin
            clk_lo_r <= dat_i[CTRL0_CLK_LO_POS +: 2];
            chan_r   <= dat_i[CTRL0_CHAN_POS +: 3];
            on_r     <= dat_i[CTRL0_ON_POS];
         end
         if (wr_ctrl1) begin
            align_r  <= dat_i[CTRL1_ALIGN_POS];
            clk_hi_r <= dat_i[CTRL1_CLK_HI_POS];
            pcfg_r   <= dat_i[CTRL1_PCFG_POS +: 4];
         end
      end
   end

   // Pin and reference routing; reset value keeps every shared pin analog
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_r  <= ALL_ANALOG;
         vpos_r <= 1'b0;
         vneg_r <= 1'b0;
      end else begin
         {vpos_r, vneg_r, pin_r} <= port_decode(pcfg_r);
      end
   end

   // Conversion sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= ST_IDLE;
         tad_cnt_r <= 4'h0;
         rec_cnt_r <= 2'h0;
         sar_r     <= 10'h000;
         mask_r    <= 10'h000;
         hold_r    <= 1'b1;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r   <= ST_CONV;
                  tad_cnt_r <= 4'h0;
                  sar_r     <= SAR_MSB;
                  mask_r    <= SAR_MSB;
                  hold_r    <= 1'b0;
               end
            end
            ST_CONV: begin
               if (abort || !on_r || complete) begin
                  state_r   <= ST_RECOVER;
                  rec_cnt_r <= 2'h0;
               end else if (cc.tick) begin
                  tad_cnt_r <= tad_cnt_r + 4'h1;
                  if (tad_cnt_r >= TAD_FIRST_BIT && tad_cnt_r <= TAD_LAST_BIT) begin
                     sar_r  <= (comp_i ? sar_r : (sar_r & ~mask_r)) | (mask_r >> 1);
                     mask_r <= mask_r >> 1;
                  end
               end
            end
            ST_RECOVER: begin
               // Acquisition restarts by itself after the two-period gap
               if (cc.tick) begin
                  rec_cnt_r <= rec_cnt_r + 2'h1;
                  if (rec_cnt_r == RECOVER_TADS - 2'h1) begin
                     state_r <= ST_IDLE;
                     hold_r  <= 1'b1;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
               hold_r  <= 1'b1;
            end
         endcase
      end
   end

   // Result registers carry no reset; completion beats a same-cycle write
   always_ff @(posedge clk_i) begin
      if (complete && !rst_i) begin
         if (align_r) begin
            res_hi_r <= {6'b00_0000, sar_r[9:8]};
            res_lo_r <= sar_r[7:0];
         end else begin
            res_hi_r <= sar_r[9:2];
            res_lo_r <= {sar_r[1:0], 6'b00_0000};
         end
      end else if (wr && adr_i == OFS_RES_HI[AW-1:0]) begin
         res_hi_r <= dat_i[7:0];
      end else if (wr && adr_i == OFS_RES_LO[AW-1:0]) begin
         res_lo_r <= dat_i[7:0];
      end
   end

   // Done flag: hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_r <= 1'b0;
         en_r   <= 1'b0;
         irq_r  <= 1'b0;
      end else begin
         if (complete) begin
            flag_r <= 1'b1;
         end else if (wr_irq) begin
            flag_r <= dat_i[IRQ_FLAG_POS];
         end
         if (wr_irq) begin
            en_r <= dat_i[IRQ_EN_POS];
         end
         irq_r <= flag_r && en_r;
      end
   end

   assign dat_o          = dat_r;
   assign ack_o          = ack_r;
   assign dac_o          = sar_r;
   assign hold_connect_o = hold_r;
   assign chan_o         = chan_r;
   assign power_on_o     = on_r;
   assign pin_analog_o   = pin_r;
   assign vref_pos_ext_o = vpos_r;
   assign vref_neg_ext_o = vneg_r;
   assign irq_o          = irq_r;

   // Helper: periods counted since the start of the running conversion
   logic [4:0] tad_seen_r;
   always_ff @(posedge clk_i) begin
      if (rst_i || start) begin
         tad_seen_r <= 5'h00;
      end else if (state_r == ST_CONV && cc.tick) begin
         tad_seen_r <= tad_seen_r + 5'h01;
      end
   end

   sequence s_complete;
      complete;
   endsequence

   sequence s_loaded;
      state_r == ST_RECOVER && flag_r && !ctrl0_rd[CTRL0_GO_POS];
   endsequence

   property p_right_align;
      s_complete and align_r |=> res_hi_r[7:2] == 6'b00_0000 && res_lo_r == $past(sar_r[7:0]);
   endproperty
   a_right_align: assert property (p_right_align) else $error("right alignment wrong");
   property p_left_align;
      s_complete and !align_r |=> res_lo_r[5:0] == 6'b00_0000 && res_hi_r == $past(sar_r[9:2]);
   endproperty
   a_left_align: assert property (p_left_align) else $error("left alignment wrong");
   property p_ctrl1_rsvd;
      req && adr_i == OFS_CTRL1[AW-1:0] |=> ack_o && dat_o[5:4] == 2'b00;
   endproperty
   a_ctrl1_rsvd: assert property (p_ctrl1_rsvd) else $error("unimplemented bits not zero");
   property p_port_map;
      $past(pcfg_r) == 4'h6 && !$past(rst_i) |-> pin_analog_o == 8'h00;
   endproperty
   a_port_map: assert property (p_port_map) else $error("all-digital code left analog pins");
   property p_vref_ext;
      pcfg_r == 4'h8 ##1 !rst_i |-> vref_pos_ext_o && vref_neg_ext_o;
   endproperty
   a_vref_ext: assert property (p_vref_ext) else $error("external references not taken");
   property p_pin_reset;
      $past(rst_i) |-> pin_analog_o == ALL_ANALOG;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pins not analog after reset");
   property p_reset_off;
      $past(rst_i) |-> state_r == ST_IDLE && !power_on_o && !flag_r;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("reset left converter active");
   property p_done;
      s_complete |=> s_loaded;
   endproperty
   a_done: assert property (p_done) else $error("completion effects not together");
   property p_hold_open;
      state_r == ST_CONV |-> !hold_connect_o;
   endproperty
   a_hold_open: assert property (p_hold_open) else $error("hold capacitor connected in conversion");
   property p_start;
      start |=> ctrl0_rd[CTRL0_GO_POS] && dac_o == SAR_MSB;
   endproperty
   a_start: assert property (p_start) else $error("go write did not start");
   property p_abort;
      abort |=> state_r == ST_RECOVER && $stable(res_hi_r) && $stable(res_lo_r);
   endproperty
   a_abort: assert property (p_abort) else $error("abort changed results");
   property p_twelve;
      complete |-> tad_seen_r == 5'h0B;
   endproperty
   a_twelve: assert property (p_twelve) else $error("conversion length not twelve periods");
   property p_irq;
      flag_r && en_r ##1 !rst_i |-> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request missing");
   property p_flag_sticky;
      flag_r && !wr_irq |=> flag_r;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("done flag dropped alone");

endmodule

// ---- src/adc_pkg.sv ----
package adc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL0   = 8'h00;
   localparam logic [7:0] OFS_CTRL1   = 8'h04;
   localparam logic [7:0] OFS_RES_HI  = 8'h08;
   localparam logic [7:0] OFS_RES_LO  = 8'h0C;
   localparam logic [7:0] OFS_IRQ     = 8'h10;

   // conv_control_reg0 fields
   localparam int CTRL0_CLK_LO_POS = 6;
   localparam int CTRL0_CHAN_POS   = 3;
   localparam int CTRL0_GO_POS     = 2;
   localparam int CTRL0_ON_POS     = 0;

   // conv_control_reg1 fields
   localparam int CTRL1_ALIGN_POS  = 7;
   localparam int CTRL1_CLK_HI_POS = 6;
   localparam int CTRL1_PCFG_POS   = 0;

   // Interrupt register fields
   localparam int IRQ_FLAG_POS     = 0;
   localparam int IRQ_EN_POS       = 1;

   // Values after reset
   localparam logic [7:0] CTRL0_RST   = 8'h00;
   localparam logic [7:0] CTRL1_RST   = 8'h00;
   localparam logic [7:0] ALL_ANALOG  = 8'hFF;

   // Sequencing counts in bit_conv_period units
   localparam logic [3:0] TAD_PER_CONV = 4'hC;
   localparam logic [3:0] TAD_FIRST_BIT = 4'h1;
   localparam logic [3:0] TAD_LAST_BIT  = 4'hA;
   localparam logic [1:0] RECOVER_TADS = 2'h2;

   localparam logic [1:0] CLK_SEL_RC   = 2'h3;
   localparam logic [9:0] SAR_MSB      = 10'h200;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_CONV    = 2'b01,
      ST_RECOVER = 2'b10
   } conv_state_t;

endpackage

// ---- src/conv_clk_if.sv ----
`timescale 1ns/100ps
interface conv_clk_if;
   logic [2:0] sel;
   logic       run;
   logic       sleep;
   logic       tick;

   modport gen (input sel, input run, input sleep, output tick);
   modport ctl (output sel, output run, output sleep, input tick);
endinterface

// ---- src/conv_tick_gen.sv ----
`timescale 1ns/100ps
module conv_tick_gen (
   // Clock and reset
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   // Internal RC clock, synchronous sample
   input  wire logic     rc_clk_i,
   // Control side
   conv_clk_if.gen       cc
);
   import adc_pkg::*;

   logic [5:0] div_cnt_r;
   logic [5:0] div_lim;
   logic       rc_prev_r;
   logic       tick_r;

   // Divide ratio minus one: lo code picks 2/8/32, hi bit doubles it
   always_comb begin
      unique case (cc.sel[1:0])
         2'b00:   div_lim = cc.sel[2] ? 6'h03 : 6'h01;
         2'b01:   div_lim = cc.sel[2] ? 6'h0F : 6'h07;
         2'b10:   div_lim = cc.sel[2] ? 6'h3F : 6'h1F;
         default: div_lim = 6'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rc_prev_r <= 1'b0;
      end else begin
         rc_prev_r <= rc_clk_i;
      end
   end

   // Oscillator divider holds during sleep; RC keeps ticking
   always_ff @(posedge clk_i) begin
      if (rst_i || !cc.run) begin
         div_cnt_r <= 6'h00;
         tick_r    <= 1'b0;
      end else if (cc.sel[1:0] == CLK_SEL_RC) begin
         div_cnt_r <= 6'h00;
         tick_r    <= rc_clk_i && !rc_prev_r;
      end else if (cc.sleep) begin
         tick_r    <= 1'b0;
      end else if (div_cnt_r >= div_lim) begin
         div_cnt_r <= 6'h00;
         tick_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 6'h01;
         tick_r    <= 1'b0;
      end
   end

   assign cc.tick = tick_r;

   property p_div2;
      @(posedge clk_i) disable iff (rst_i)
      tick_r && cc.sel == 3'b000 && cc.run && !cc.sleep ##1 cc.sel == 3'b000 && cc.run && !cc.sleep
         |-> !tick_r;
   endproperty
   a_div2: assert property (p_div2) else $error("Fosc/2 tick spacing wrong");

   property p_sleep_hold;
      @(posedge clk_i) disable iff (rst_i)
      cc.sleep && $past(cc.sleep) && cc.sel[1:0] != CLK_SEL_RC && $past(cc.sel[1:0]) != CLK_SEL_RC
         |-> !tick_r;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("oscillator clock ran in sleep");
endmodule

// ---- sim/analog_front_model.sv ----
`timescale 1ns/100ps
module analog_front_model #(
   parameter int RC_HALF_NS = 20
) (
   // Clock
   input  wire logic       clk_i,
   // Converter side
   input  wire logic       hold_i,
   input  wire logic [9:0] trial_i,
   // Pin voltage, in result codes
   input  wire logic [9:0] vin_i,
   // Comparator and RC oscillator
   output logic            comp_o,
   output logic            rc_clk_o
);
   logic [9:0] held_r;

   // Capacitor follows the pin only while connected; frozen once conversion starts
   always_ff @(posedge clk_i) begin
      if (hold_i) begin
         held_r <= vin_i;
      end
   end

   assign comp_o = (held_r >= trial_i);

   // Internal oscillator runs free, unrelated to the system clock
   initial rc_clk_o = 1'b0;
   always #(RC_HALF_NS) rc_clk_o = ~rc_clk_o;
endmodule

// ---- sim/test_adc_ctrl.sv ----
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module test_adc_ctrl;
   import adc_pkg::*;
   localparam int RC_DIV = 10;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic        sleep_i = 1'b0;
   logic [9:0]  vin = 10'h000;
   logic [31:0] dat_o, rd;
   logic        ack_o, comp_i, rc_clk_i, hold_connect_o, power_on_o, irq_o;
   logic        vref_pos_ext_o, vref_neg_ext_o;
   logic [9:0]  dac_o;
   logic [2:0]  chan_o;
   logic [7:0]  pin_analog_o, exp_hi, exp_lo;
   int          num_errors = 0;
   int          total_checks = 0;
   // {external positive ref, external negative ref, analog pin mask}
   // Pins taken as references drop out of the analog mask
   logic [9:0]  pcfg_exp [16] = '{10'h0FF, 10'h2F7, 10'h01F, 10'h217, 10'h00B, 10'h203, 10'h000, 10'h000,
                                  10'h3F3, 10'h03F, 10'h237, 10'h333, 10'h313, 10'h303, 10'h001, 10'h301};

   always #2 clk_i = ~clk_i;

   adc_ctrl #(.AW(8)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .comp_i(comp_i), .rc_clk_i(rc_clk_i),
      .sleep_i(sleep_i), .dac_o(dac_o), .hold_connect_o(hold_connect_o), .chan_o(chan_o),
      .power_on_o(power_on_o), .pin_analog_o(pin_analog_o), .vref_pos_ext_o(vref_pos_ext_o),
      .vref_neg_ext_o(vref_neg_ext_o), .irq_o(irq_o));

   analog_front_model #(.RC_HALF_NS(20)) afe (
      .clk_i(clk_i), .hold_i(hold_connect_o), .trial_i(dac_o), .vin_i(vin), .comp_o(comp_i),
      .rc_clk_o(rc_clk_i));

   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Classic single cycle; held until ack, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= {24'h00_0000, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rdr(input logic [7:0] a);
      wb(1'b0, a, 8'h00);
   endtask

   task automatic start(input logic [2:0] cs, input logic al);
      wr(OFS_CTRL1, {al, cs[2], 6'h00});
      wr(OFS_CTRL0, {cs[1:0], 6'h09}); // Channel 1, power on first
      repeat (20) @(posedge clk_i); // Acquisition before go, room temperature so no extra term
      wr(OFS_CTRL0, {cs[1:0], 6'h0D});
   endtask

   task automatic conv(input logic [2:0] cs, input logic al, input logic slp);
      realtime t0;
      int      d;
      int      n;
      d = (cs[1:0] == 2'b11) ? RC_DIV : 2 << (2 * cs[1:0] + cs[2]);
      vin <= 10'h2B5 ^ {cs, 7'h00};
      wr(OFS_IRQ, {6'h00, al, 1'b0});
      start(cs, al);
      t0 = $realtime;
      if (slp) begin
         sleep_i <= 1'b1;
         repeat (200) @(posedge clk_i);
         rdr(OFS_CTRL0); `CHK("go in sleep", cs[1:0] != 2'b11, rd[2])
         sleep_i <= 1'b0;
      end else begin
         rdr(OFS_CTRL0); `CHK("go running", 1'b1, rd[2])
      end
      do rdr(OFS_CTRL0); while (rd[2] === 1'b1);
      n = int'(($realtime - t0) / 4.0);
      if (!slp) `CHK("conv time", 1'b1, n >= 11 * d - 2 && n <= 12 * d + 12)
      exp_hi = al ? {6'h00, vin[9:8]} : vin[9:2];
      exp_lo = al ? vin[7:0] : {vin[1:0], 6'h00};
      rdr(OFS_RES_HI); `CHK("result high", exp_hi, rd[7:0])
      rdr(OFS_RES_LO); `CHK("result low", exp_lo, rd[7:0])
      rdr(OFS_IRQ); `CHK("done flag", 1'b1, rd[0])
      `CHK("irq line", al, irq_o)
      wr(OFS_IRQ, {6'h00, al, 1'b0});
      `CHK("irq cleared", 1'b0, irq_o)
      repeat (2 * d + 4) @(posedge clk_i); // Gap before next acquisition
   endtask

   initial begin
      repeat (50000) @(posedge clk_i);
      num_errors++;
      $display("mismatch watchdog expected done seen timeout");
      results();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdr(OFS_CTRL0); `CHK("ctrl0 reset", 8'h00, rd[7:0])
      `CHK("pins reset", 8'hFF, pin_analog_o)
      `CHK("outputs reset", 4'b0100, {power_on_o, hold_connect_o, vref_pos_ext_o, vref_neg_ext_o})
      rdr(OFS_CTRL1); `CHK("ctrl1 reset", 8'h00, rd[7:0])
      rdr(8'h14); `CHK("unmapped", 32'h0000_0000, rd)
      wr(OFS_CTRL1, 8'hFF); rdr(OFS_CTRL1); `CHK("ctrl1 unused", 32'h0000_00CF, rd)
      for (int c = 0; c < 16; c++) begin
         wr(OFS_CTRL1, 8'(c));
         `CHK("port config", pcfg_exp[c], {vref_pos_ext_o, vref_neg_ext_o, pin_analog_o})
      end
      wr(OFS_CTRL0, 8'h05); rdr(OFS_CTRL0); `CHK("go with power-on", 8'h01, rd[7:0])
      for (int k = 0; k < 8; k++) begin
         conv(3'(k), k[0], 1'b0);
      end
      conv(3'b000, 1'b0, 1'b1);
      conv(3'b111, 1'b1, 1'b1);
      // Abort must leave the previous result in place
      vin <= 10'h155;
      start(3'b110, 1'b1);
      repeat (100) @(posedge clk_i);
      wr(OFS_CTRL0, 8'h89); rdr(OFS_CTRL0); `CHK("abort go", 8'h89, rd[7:0])
      rdr(OFS_RES_HI); `CHK("abort high", exp_hi, rd[7:0])
      rdr(OFS_RES_LO); `CHK("abort low", exp_lo, rd[7:0])
      rdr(OFS_IRQ); `CHK("abort flag", 8'h02, rd[7:0])
      repeat (140) @(posedge clk_i);
      // Reset in mid-conversion with all pins digital
      wr(OFS_CTRL1, 8'h46); `CHK("digital pins", 8'h00, pin_analog_o)
      wr(OFS_CTRL0, 8'h8D);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK("pins after reset", 8'hFF, pin_analog_o)
      `CHK("state after reset", 5'b01000, {power_on_o, hold_connect_o, chan_o})
      repeat (1000) @(posedge clk_i);
      rdr(OFS_CTRL0); `CHK("ctrl0 after reset", 8'h00, rd[7:0])
      rdr(OFS_IRQ); `CHK("no completion", 8'h00, rd[7:0])
      results();
   end
endmodule
